// >>> sra_adc_top.sv
// Conversion control and three-wire serial readout of a 12-bit SUCCESSIVE_APPROX_REGISTER converter.
// Assumes select, serial clock and the three-level power-down pin arrive
// asynchronously; comparator input is settled logic on the system clock.
`timescale 1ns/10ps

module sra_adc_top
    import sra_pkg::*;
#(
    parameter int CONV_CYC = CONV_CYCLES,
    parameter int DEPTH = FIFO_DEPTH
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // Serial port pins
    input wire logic cs_n_i,
    input wire logic sclk_i,
    output logic dout_o,
    output logic dout_oe_o,
    // Three-level power-down pin, decoded by the pad
    input wire logic power_down_n_i,
    input wire logic power_down_float_i,
    // Analog core
    input wire logic comp_i,
    output logic [RES_BITS-1:0] dac_code_o,
    output logic hold_o,
    output logic shutdown_o,
    output logic ref_internal_o,
    // Result side channel
    output sra_result_t result_o,
    output logic result_valid_o
);

    localparam int BIT_CYC = CONV_CYC / RES_BITS;
    localparam int CNT_W = $clog2(CONV_CYC + 2);
    localparam int BIT_W = $clog2(BIT_CYC + 1);
    localparam int IDX_W = $clog2(RES_BITS);

    if (BIT_CYC < 1) begin : g_bad_conv
        $error("conversion count too short for one cycle per bit");
    end
    if (CONV_TIME_NS + ACQ_MIN_NS > FULL_CYCLE_NS) begin : g_bad_cycle
        $error("acquisition plus conversion exceeds full cycle time");
    end
    if (CODE_STEPS != (1 << RES_BITS)) begin : g_bad_code
        $error("code steps do not match resolution");
    end

    function automatic logic [RES_BITS-1:0] trial_code(
        input logic [RES_BITS-1:0] code,
        input logic [IDX_W-1:0] idx
    );
        trial_code = code | (RES_BITS'(1) << idx);
    endfunction

    function automatic logic fell(input logic prev, input logic now);
        fell = prev && !now;
    endfunction

    // Pin synchronisation and edges
    sra_pins_t pins_raw;
    sra_pins_t pins_s;
    sra_pins_t pins_d;
    logic cs_fall;
    logic sclk_fall;
    logic shutdown;

    assign pins_raw = '{cs_n: cs_n_i, sclk: sclk_i, pd_n: power_down_n_i,
                        pd_float: power_down_float_i};

    sra_sync #(
        .W($bits(sra_pins_t)),
        .RST_VAL(PINS_RST)
    ) u_sync (
        .clk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .d_i(pins_raw),
        .q_o(pins_s)
    );

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            pins_d <= PINS_RST;
        end else begin
            pins_d <= pins_s;
        end
    end

    assign cs_fall = fell(pins_d.cs_n, pins_s.cs_n);
    assign sclk_fall = fell(pins_d.sclk, pins_s.sclk);
    assign shutdown = !pins_s.pd_n;

    // Mode outputs
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            shutdown_o <= 1'b0;
            ref_internal_o <= 1'b0;
        end else begin
            shutdown_o <= shutdown;
            ref_internal_o <= pins_s.pd_n && !pins_s.pd_float;
        end
    end

    // Sequencer
    sra_state_t state;
    sra_state_t next_state;
    logic fifo_out_valid;
    logic fifo_out_ready;
    sra_result_t fifo_out;

    always_comb begin
        next_state = state;
        if (shutdown || pins_s.cs_n) begin
            next_state = ST_IDLE;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    if (cs_fall) begin
                        next_state = ST_CONVERT;
                    end
                end
                ST_CONVERT: begin
                    if (fifo_out_valid) begin
                        next_state = ST_READOUT;
                    end
                end
                ST_READOUT: begin
                    next_state = ST_READOUT;
                end
            endcase
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Successive approximation engine, runs only while converting
    logic [CNT_W-1:0] conv_cnt;
    logic [BIT_W-1:0] bit_tmr;
    logic [IDX_W-1:0] bit_idx;
    logic [RES_BITS-1:0] sar_code;
    logic bits_done;
    logic sar_pushed;
    logic conv_end;
    logic fifo_in_valid;
    logic fifo_in_ready;
    sra_result_t fifo_in;

    assign conv_end = (state == ST_CONVERT) && (conv_cnt == CNT_W'(CONV_CYC - 1));
    assign fifo_in_valid = conv_end && !sar_pushed;
    assign fifo_in = '{ref_internal: ref_internal_o, code: sar_code};

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i || state != ST_CONVERT) begin
            conv_cnt <= '0;
            bit_tmr <= '0;
            bit_idx <= IDX_W'(RES_BITS - 1);
            sar_code <= '0;
            bits_done <= 1'b0;
            sar_pushed <= 1'b0;
        end else begin
            // Counter parks at the end; a stalled FIFO holds the result here
            if (!conv_end) begin
                conv_cnt <= conv_cnt + 1'b1;
            end
            if (fifo_in_valid && fifo_in_ready) begin
                sar_pushed <= 1'b1;
            end
            if (!bits_done) begin
                if (bit_tmr == BIT_W'(BIT_CYC - 1)) begin
                    bit_tmr <= '0;
                    if (comp_i) begin
                        sar_code <= trial_code(sar_code, bit_idx);
                    end
                    if (bit_idx == '0) begin
                        bits_done <= 1'b1;
                    end else begin
                        bit_idx <= bit_idx - 1'b1;
                    end
                end else begin
                    bit_tmr <= bit_tmr + 1'b1;
                end
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            dac_code_o <= '0;
            hold_o <= 1'b0;
        end else begin
            dac_code_o <= (state == ST_CONVERT && !bits_done) ?
                          trial_code(sar_code, bit_idx) : sar_code;
            // Track resumes as soon as the conversion count reaches its end
            hold_o <= (next_state == ST_CONVERT) && !conv_end;
        end
    end

    // Result buffer between engine and shifter; idle drains aborted leftovers
    assign fifo_out_ready = (state != ST_READOUT);

    sra_fifo #(
        .W($bits(sra_result_t)),
        .DEPTH(DEPTH)
    ) u_fifo (
        .clk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .in_valid_i(fifo_in_valid),
        .in_ready_o(fifo_in_ready),
        .in_data_i(fifo_in),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(fifo_out_ready),
        .out_data_o(fifo_out)
    );

    // Output shifter
    logic [FRAME_BITS-1:0] shreg;
    logic [FRAME_BITS-1:0] next_shreg;
    logic load;

    assign load = (state == ST_CONVERT) && (next_state == ST_READOUT);

    always_comb begin
        next_shreg = shreg;
        if (load) begin
            next_shreg = {EOC_LEVEL, fifo_out.code};
        end else if (state == ST_READOUT && sclk_fall) begin
            next_shreg = {shreg[FRAME_BITS-2:0], TRAIL_LEVEL};
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            shreg <= '0;
        end else begin
            shreg <= next_shreg;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            dout_o <= 1'b0;
            dout_oe_o <= 1'b0;
        end else begin
            dout_oe_o <= (next_state != ST_IDLE);
            // Low while converting; high on completion; shifts on falls only
            dout_o <= (next_state == ST_READOUT) ? next_shreg[FRAME_BITS-1] : 1'b0;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            result_o <= '0;
            result_valid_o <= 1'b0;
        end else begin
            result_valid_o <= load;
            if (load) begin
                result_o <= fifo_out;
            end
        end
    end

    // Checking helper: cycles spent converting
    logic [CNT_W:0] conv_age;

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i || state != ST_CONVERT) begin
            conv_age <= '0;
        end else begin
            conv_age <= conv_age + 1'b1;
        end
    end

    a_start_hold: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (state == ST_IDLE && next_state == ST_CONVERT) |=> hold_o && state == ST_CONVERT)
        else $error("select fall did not start a held conversion");

    a_convert_low: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (state == ST_CONVERT) |-> (dout_oe_o && !dout_o))
        else $error("output not driven low during conversion");

    a_eoc_timing: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (state == ST_READOUT && $past(state) == ST_CONVERT) |->
            (dout_o && conv_age >= (CNT_W + 1)'(CONV_CYC + 1)))
        else $error("end of conversion early or not high");

    a_result_held: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (state == ST_READOUT && next_state == ST_READOUT && !sclk_fall) |=> $stable(shreg))
        else $error("result register moved without a clock fall");

    a_fall_only: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (state == ST_READOUT && $past(state) == ST_READOUT && $changed(dout_o)) |->
            $past(sclk_fall))
        else $error("output changed without a clock fall");

    a_shift_order: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (state == ST_READOUT && next_state == ST_READOUT && sclk_fall) |=>
            (dout_o == $past(shreg[FRAME_BITS-2])))
        else $error("output bit out of order");

    a_trail_zero: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (state == ST_READOUT && next_state == ST_READOUT && sclk_fall &&
         shreg[FRAME_BITS-2:0] == '0) |=> (!dout_o ##1 $stable(conv_cnt)))
        else $error("trailing bits not zero");

    a_track_after: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        conv_end |=> !hold_o)
        else $error("hold not released at conversion end");

    a_shutdown_idle: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        shutdown |=> (state == ST_IDLE && shutdown_o) ##1 !dout_oe_o)
        else $error("shutdown did not stop the converter");

    a_ref_select: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (pins_s.pd_n) |=> (ref_internal_o == !$past(pins_s.pd_float)))
        else $error("reference selection wrong");

    a_select_hiz: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        pins_s.cs_n |=> !dout_oe_o)
        else $error("output driven while select high");

endmodule

// >>> sra_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock; depth must be a power of two.
`timescale 1ns/10ps
module sra_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [W-1:0] in_data_i,
    // Drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [W-1:0] out_data_o
);

    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("sra_fifo depth must be a power of two, at least 2");
    end

    logic [W-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
    logic push;
    logic pop;

    assign in_ready_o = (wr_ptr ^ rd_ptr) != {1'b1, {AW{1'b0}}};
    assign out_valid_o = wr_ptr != rd_ptr;
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;
    assign out_data_o = mem[rd_ptr[AW-1:0]];

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr[AW-1:0]] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end

endmodule

// >>> sra_host_model.sv
// Host-side serial master: drives select and serial clock, reads one frame.
// Assumes the bench resolves the data pin level and mclk_i runs at 40 MHz.
`timescale 1ns/10ps
module sra_host_model
    import sra_pkg::*;
(
    // Clock
    input wire logic mclk_i,
    // Serial port
    input wire logic dout_i,
    output logic cs_n_o,
    output logic sclk_o
);
    initial begin
        cs_n_o = 1'b1;
        sclk_o = 1'b0;
    end

    task automatic frame(input int nclk, input int stall, output logic [15:0] bits,
        output int conv);
        bits = 16'h0000;
        conv = 0;
        @(negedge mclk_i);
        cs_n_o = 1'b0;
        // A released pin may read high, so frame on a true rising edge
        while (dout_i !== 1'b0 && conv < 1000) begin
            @(negedge mclk_i);
            conv++;
        end
        // Clock stays still until the data pin rises
        while (dout_i !== 1'b1 && conv < 1000) begin
            @(negedge mclk_i);
            conv++;
        end
        repeat (stall) @(negedge mclk_i);
        // Long low phase covers the pin filter delay before each rising edge
        for (int i = 0; i < nclk; i++) begin
            bits = {bits[14:0], dout_i};
            sclk_o = 1'b1;
            #100;
            sclk_o = 1'b0;
            #150;
        end
        bits = {bits[14:0], dout_i};
        @(negedge mclk_i);
        cs_n_o = 1'b1;
        repeat (ACQ_CYCLES) @(negedge mclk_i);
    endtask

    task automatic abort(input int len);
        @(negedge mclk_i);
        cs_n_o = 1'b0;
        repeat (len) @(negedge mclk_i);
        cs_n_o = 1'b1;
        repeat (ACQ_CYCLES) @(negedge mclk_i);
    endtask
endmodule

// >>> sra_pkg.sv
// Shared constants, carriers and states for the serial converter readout.
// Assumes a 40 MHz system clock; all pin timing is measured against it.
package sra_pkg;

    localparam int CLK_FREQ_MHZ = 40;

    // Conversion is self-timed; a longest time, so it rounds down
    localparam int CONV_TIME_NS = 8500;
    localparam int CONV_CYCLES = (CONV_TIME_NS * CLK_FREQ_MHZ) / 1000;

    // Track interval after a conversion; a least time, so it rounds up
    localparam int ACQ_MIN_NS = 1500;
    localparam int ACQ_CYCLES = (ACQ_MIN_NS * CLK_FREQ_MHZ + 999) / 1000;

    // Acquisition plus conversion must fit in this
    localparam int FULL_CYCLE_NS = 10000;

    localparam int RES_BITS = 12;
    localparam int CODE_STEPS = 4096;
    localparam int FRAME_BITS = RES_BITS + 1;
    localparam int FIFO_DEPTH = 16;

    localparam logic EOC_LEVEL = 1'b1;
    localparam logic TRAIL_LEVEL = 1'b0;

    typedef struct packed {
        logic ref_internal;
        logic [RES_BITS-1:0] code;
    } sra_result_t;

    typedef struct packed {
        logic cs_n;
        logic sclk;
        logic pd_n;
        logic pd_float;
    } sra_pins_t;

    // Select idle high, clock low, operating, driven
    localparam sra_pins_t PINS_RST = 4'ha;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_CONVERT,
        ST_READOUT
    } sra_state_t;

endpackage

// >>> sra_sync.sv
// Three-stage pin synchroniser with agreement filter.
// Assumes asynchronous pin levels; output moves only when stages two and three agree.
`timescale 1ns/10ps
module sra_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Levels
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);

    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            s1 <= RST_VAL;
            s2 <= RST_VAL;
            s3 <= RST_VAL;
        end else begin
            s1 <= d_i;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // Per bit, so one noisy pin does not hold back the others
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            q_o <= RST_VAL;
        end else begin
            for (int i = 0; i < W; i++) begin
                if (s2[i] == s3[i]) begin
                    q_o[i] <= s3[i];
                end
            end
        end
    end

endmodule

// >>> tb.sv
// Bench for the serial converter readout: reset, then a table of frames,
// then abort, shutdown and mid-run reset cases.
// Assumes the host model file and the default conversion length.
`timescale 1ns/10ps
module tb;
    import sra_pkg::*;
    typedef struct {
        logic [RES_BITS-1:0] analog_input;
        logic pd_n;
        logic pd_float;
        int nclk;
        int stall;
    } sra_row_t;
    logic mclk, rst_n, cs_n, sclk, dout, dout_oe, pd_n, pd_float, comp, hold, shutdown;
    logic ref_int, result_valid, junk, dout_pin, dprev, sprev, eoc_seen;
    logic [RES_BITS-1:0] dac_code, analog_input;
    sra_result_t result, got_res;
    logic [15:0] bits;
    int errors, comparisons, conv, since_fall, cs_high;
    sra_row_t rows [5] = '{
        '{12'h000, 1'b1, 1'b0, 15, 0},
        '{12'hfff, 1'b1, 1'b1, 15, 0},
        '{12'ha5a, 1'b1, 1'b0, 13, 0},
        '{12'h801, 1'b1, 1'b1, 15, 200},
        '{12'h7fe, 1'b1, 1'b0, 14, 0}
    };

    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    sra_adc_top u_dut (
        .mclk_i(mclk), .rst_n_i(rst_n), .cs_n_i(cs_n), .sclk_i(sclk),
        .dout_o(dout), .dout_oe_o(dout_oe), .power_down_n_i(pd_n),
        .power_down_float_i(pd_float), .comp_i(comp), .dac_code_o(dac_code),
        .hold_o(hold), .shutdown_o(shutdown), .ref_internal_o(ref_int),
        .result_o(result), .result_valid_o(result_valid)
    );
    sra_host_model u_host (.mclk_i(mclk), .dout_i(dout_pin), .cs_n_o(cs_n), .sclk_o(sclk));

    // Ideal comparator; released pin shows the inverse of the last driven bit
    assign comp = (analog_input >= dac_code);
    assign dout_pin = dout_oe ? dout : junk;

    task automatic chk1(input string name, input logic exp, input logic got);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("FAIL %s expected %b seen %b", name, exp, got);
        end
    endtask
    task automatic chk16(input string name, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("FAIL %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic chk_rng(input string name, input int lo, input int hi, input int got);
        comparisons++;
        if (got < lo || got > hi) begin
            errors++;
            $display("FAIL %s expected %0d..%0d seen %0d", name, lo, hi, got);
        end
    endtask

    task automatic print_verdict();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    always @(posedge mclk) begin
        if (dout_oe === 1'b1) junk <= ~dout;
        dprev <= dout;
        sprev <= sclk;
        since_fall <= (sprev && !sclk) ? 0 : since_fall + 1;
        cs_high <= cs_n ? cs_high + 1 : 0;
        if (cs_n) eoc_seen <= 1'b0;
        else if (dout === 1'b1) eoc_seen <= 1'b1;
        if (result_valid === 1'b1) got_res <= result;
        if (dout_oe === 1'b1 && eoc_seen && since_fall > 6) chk1("dout off fall", dprev, dout);
        if (hold === 1'b1 && dout_oe === 1'b1) chk1("dout in conversion", 1'b0, dout);
        if (cs_high > 6) chk1("oe while deselected", 1'b0, dout_oe);
    end

    task automatic run_frame(input sra_row_t r, input string name);
        logic [15:0] exp;
        @(negedge mclk);
        analog_input = r.analog_input;
        pd_n = r.pd_n;
        pd_float = r.pd_float;
        repeat (8) @(negedge mclk);
        u_host.frame(r.nclk, r.stall, bits, conv);
        exp = {1'b1, r.analog_input, 3'b000} >> (15 - r.nclk);
        chk16({name, " frame"}, exp, bits);
        chk_rng("conversion cycles", CONV_CYCLES + 3, CONV_CYCLES + 8, conv);
        chk16("result code", {4'h0, r.analog_input}, {4'h0, got_res.code});
        chk1("result reference", r.pd_n & ~r.pd_float, got_res.ref_internal);
        chk1("reference pin", r.pd_n & ~r.pd_float, ref_int);
        chk1("hold released", 1'b0, hold);
        $display("test %s done", name);
    endtask

    initial begin
        repeat (20000) @(posedge mclk);
        errors++;
        print_verdict();
    end

    initial begin
        rst_n = 1'b0;
        pd_n = 1'b1;
        pd_float = 1'b0;
        analog_input = 12'h000;
        junk = 1'b1;
        {dprev, sprev, eoc_seen} = 3'b000;
        errors = 0;
        comparisons = 0;
        since_fall = 0;
        cs_high = 0;
        // All synchroniser stages take their reset value on the same edge
        repeat (3) @(negedge mclk);
        rst_n = 1'b1;
        chk1("oe after reset", 1'b0, dout_oe);
        chk1("hold after reset", 1'b0, hold);
        chk1("shutdown after reset", 1'b0, shutdown);
        chk16("dac after reset", 16'h0000, {4'h0, dac_code});
        $display("test reset done");
        // Ideal comparator, so no reference settling is waited for
        repeat (8) @(negedge mclk);
        foreach (rows[i]) run_frame(rows[i], "row");
        fork
            u_host.abort(100);
            begin
                repeat (8) @(negedge mclk);
                chk1("hold at start", 1'b1, hold);
                chk1("oe at start", 1'b1, dout_oe);
                chk1("dout at start", 1'b0, dout);
                repeat (100) @(negedge mclk);
                chk1("oe after abort", 1'b0, dout_oe);
            end
        join
        $display("test abort done");
        run_frame('{12'h3c3, 1'b1, 1'b0, 15, 0}, "after abort");
        pd_n = 1'b0;
        repeat (8) @(negedge mclk);
        chk1("shutdown", 1'b1, shutdown);
        fork
            u_host.abort(40);
            begin
                repeat (10) @(negedge mclk);
                chk1("oe in shutdown", 1'b0, dout_oe);
            end
        join
        pd_n = 1'b1;
        repeat (8) @(negedge mclk);
        chk1("awake", 1'b0, shutdown);
        $display("test shutdown done");
        repeat (80) @(negedge mclk);
        run_frame('{12'h155, 1'b1, 1'b0, 15, 0}, "after shutdown");
        // Reset lands mid-conversion and is held until the pins are idle again
        fork
            u_host.frame(15, 0, bits, conv);
            begin
                repeat (100) @(negedge mclk);
                rst_n = 1'b0;
                repeat (5) @(negedge mclk);
                chk1("oe in reset", 1'b0, dout_oe);
                chk1("hold in reset", 1'b0, hold);
            end
        join
        rst_n = 1'b1;
        $display("test mid-run reset done");
        repeat (8) @(negedge mclk);
        run_frame('{12'h9e1, 1'b1, 1'b1, 15, 0}, "after reset");
        print_verdict();
    end
endmodule
